// file: sim/pfsm_pin_model.sv
// Purpose: board-side model of the pads around the pin function mux
// Assumes: every pad carries a weak pull-up to the high level
// Notes: the bench decides where the board drives and with what value
`default_nettype none
module pfsm_pin_model (
    input wire logic [31:0] drv_out, // device drive values {D,C,B,A}
    input wire logic [31:0] drv_oe, // device drive enables
    input wire logic [31:0] ext_val, // board drive values
    input wire logic [31:0] ext_en, // board drive enables
    output logic [31:0] pin // resolved pad levels
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************
    // pad resolution
    // ****************************************************
    // device drive wins; a released pad floats to the pull-up, never holds old data
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            pin[i] = drv_oe[i] ? drv_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule : pfsm_pin_model
`default_nettype wire

// file: sim/pfsm_top_tb.sv
// Purpose: self-checking bench for the pin function select mux
// Assumes: APB answer timing as the design hands over; pads pulled up
// Notes: expectations come from bench functions, never from design outputs
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module pfsm_top_tb;
    import pfsm_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, psel, penable, pwrite, lp, wake, pready, pslverr, err, s1;
    logic [7:0] paddr, pa_o, pa_e, pb_o, pb_e, pc_o, pc_e, pd_o, pd_e, s0;
    logic [31:0] pwdata, prdata, rd, ext_val, ext_en, pin;
    logic [3:0] alt_ok, strb;
    logic [1:0] cc;
    logic [13:0] exp_pad;
    pfsm_periph_out_s pout;
    pfsm_periph_in_s p_in;
    int failures = 0;
    int check_count = 0;
    pfsm_top i_pfsm_top (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(strb), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .PA_IN(pin[7:0]), .PB_IN(pin[15:8]),
        .PC_IN(pin[23:16]), .PD_IN(pin[31:24]), .PA_OUT(pa_o), .PA_OE(pa_e),
        .PB_OUT(pb_o), .PB_OE(pb_e), .PC_OUT(pc_o), .PC_OE(pc_e), .PD_OUT(pd_o),
        .PD_OE(pd_e), .ALT_SEL_OK(alt_ok), .LOW_POWER(lp), .PERIPH_OUT(pout),
        .PERIPH_IN(p_in), .WAKE_REQ(wake));
    pfsm_pin_model i_pfsm_pin_model (.drv_out({pd_o, pc_o, pb_o, pa_o}),
        .drv_oe({pd_e, pc_e, pb_e, pa_e}), .ext_val(ext_val), .ext_en(ext_en), .pin(pin));
    // ****************************************************
    // helpers
    // ****************************************************
    // free-running core clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        // a slave that never answers ends the run as a failure
        if (n >= 50) begin
            failures++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // outputs are registered, so let selections land first
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask : settle
    // falling edge on one port A pad, then look for the wake pulse
    task automatic fall(input int i, input logic w);
        @(posedge clk);
        ext_val[i] <= 1'b0;
        @(posedge clk);
        #1;
        `CHK("wake", w, wake)
        @(posedge clk);
        #1;
        `CHK("wake_end", 1'b0, wake)
        ext_val[i] <= 1'b1;
    endtask : fall
    // routed peripheral inputs; port D fields stay at shared-gpio codes
    function automatic logic [8:0] route_exp(input logic [7:0] s, input logic t,
        input logic [31:0] p);
        return {s[1] ? p[13] : p[22], s[2] ? p[14] : p[21], s[3] ? p[3] : p[20],
            s[4] ? p[1] : p[8], s[5] ? p[2] : p[9], s[6] ? p[29] : p[31],
            p[17], 1'b1, t ? p[31] : p[29]};
    endfunction : route_exp
    // expected {oe, oe and out} of a pad for a field code
    function automatic logic [1:0] pad(input logic [1:0] c, input logic [1:0] f1,
        input logic [1:0] f2);
        logic [1:0] r;
        r = (c == 2'b01) ? f1 : (c == 2'b10) ? f2 : 2'b00;
        return {r[1], r[1] & r[0]};
    endfunction : pad
    task automatic wrap_up;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    // hang guard, far beyond the roughly one thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        wrap_up();
    end
    // ****************************************************
    // test sequence
    // ****************************************************
    initial begin
        {rst, psel, penable, pwrite, lp, paddr, pwdata} = '1;
        {psel, penable, pwrite, lp, paddr, pwdata} = '0;
        {alt_ok, strb, ext_val, ext_en, pout} = {4'hf, 4'hf, 32'hffffffff, 32'h0, 10'h0};
        void'($urandom(32'h49b45b9c));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        settle();
        `CHK("oe_rst", 32'h0, {pd_e, pc_e, pb_e, pa_e})
        `CHK("in_rst", 9'h1ff, p_in)
        apb(1'b0, OFF_PORT_DATA, 32'h0);
        `CHK("data_rst", 32'hffffffff, rd)
        apb(1'b0, OFF_PORT_CTRL, 32'h0);
        `CHK("ctrl_rst", 32'hffffffff, rd)
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, 8'(4 * k), 32'h0);
            `CHK("sel_rst", 32'h0, rd)
        end
        apb(1'b1, OFF_PORT_CTRL, 32'hfffffffe);
        settle();
        `CHK("first_out", 2'b11, {pa_e[0], pa_o[0]})
        apb(1'b1, OFF_PORT_CTRL, 32'hffffffff);
        // only the strobed byte lane may change
        strb <= 4'h1;
        apb(1'b1, OFF_PORT_DATA, 32'h0);
        strb <= 4'hf;
        apb(1'b0, OFF_PORT_DATA, 32'h0);
        `CHK("lane0", 32'hffffff00, rd)
        apb(1'b1, OFF_PC_HI_SEL, 32'hffffffff);
        apb(1'b0, OFF_PC_HI_SEL, 32'h0);
        `CHK("pc_top", 32'h3f, rd)
        apb(1'b1, OFF_IN_SRC1, 32'hffffffff);
        apb(1'b0, OFF_IN_SRC1, 32'h0);
        `CHK("src1_top", 32'h01, rd)
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped", 1'b1, err)
        // serial pins assigned before any peripheral use
        apb(1'b1, OFF_PC_HI_SEL, 32'h2a);
        ext_en <= 32'hffffffff;
        repeat (40) begin
            s0 = 8'($urandom) | 8'h01;
            s1 = 1'($urandom);
            @(posedge clk);
            ext_val <= 32'($urandom);
            apb(1'b1, OFF_IN_SRC0, {24'h0, s0});
            apb(1'b1, OFF_IN_SRC1, {31'h0, s1});
            settle();
            `CHK("route", route_exp(s0, s1, ext_val),
                p_in)
            // every pad is an input here, so the level read is the board value
            apb(1'b0, OFF_PIN_LEVEL, 32'h0);
            `CHK("pin_lvl", ext_val, rd)
        end
        // unassigned sources idle high; rx1 follows pd7 only once pd7 is given to it
        ext_val <= 32'h0;
        apb(1'b1, OFF_PC_HI_SEL, 32'h0);
        apb(1'b1, OFF_PD_HI_SEL, 32'h80);
        apb(1'b1, OFF_IN_SRC0, 32'h81);
        apb(1'b1, OFF_IN_SRC1, 32'h0);
        settle();
        `CHK("idle_src", 9'b111_001_000, p_in)
        ext_en <= 32'h0;
        for (int c = 0; c < 4; c++) begin
            repeat (2) begin
                cc = 2'(c);
                @(posedge clk);
                pout <= pfsm_periph_out_s'(10'($urandom));
                apb(1'b1, OFF_PC_HI_SEL, {26'h0, {3{cc}}});
                apb(1'b1, OFF_PD_HI_SEL, {24'h0, {4{cc}}});
                settle();
                exp_pad = {pad(cc, 2'b00, {pout.scs_oe, pout.scs_o}),
                    pad(cc, 2'b00, {pout.sck_oe, pout.sck_o}),
                    pad(cc, 2'b00, {pout.sda_oe, pout.sda_o}),
                    pad(cc, 2'b00, {pout.u1_line_oe, pout.u1_line_o}),
                    pad(cc, {1'b1, pout.t1_out}, {1'b1, pout.u1_tx}),
                    pad(cc, 2'b00, {pout.u1_line_oe, pout.u1_line_o}),
                    pad(cc, {1'b1, pout.t1_out}, {1'b1, pout.u1_tx})};
                `CHK("pads", exp_pad, {pc_e[6], pc_e[6] & pc_o[6],
                    pc_e[5], pc_e[5] & pc_o[5], pc_e[4], pc_e[4] & pc_o[4], pd_e[7],
                    pd_e[7] & pd_o[7], pd_e[6], pd_e[6] & pd_o[6], pd_e[5],
                    pd_e[5] & pd_o[5], pd_e[4],
                    pd_e[4] & pd_o[4]})
            end
        end
        ext_val <= 32'hffffffff;
        ext_en <= 32'hffffffff;
        apb(1'b1, OFF_WAKE_EN, 32'h01);
        lp <= 1'b1;
        fall(0, 1'b1);
        fall(1, 1'b0);
        // the status bit stays until software writes a one to it
        apb(1'b0, OFF_WAKE_STAT, 32'h0);
        `CHK("wake_st", 32'h01, rd)
        apb(1'b1, OFF_WAKE_STAT, 32'h01);
        apb(1'b0, OFF_WAKE_STAT, 32'h0);
        `CHK("wake_clr", 32'h0, rd)
        lp <= 1'b0;
        fall(0, 1'b0);
        wrap_up();
    end
endmodule : pfsm_top_tb
`default_nettype wire

// file: verilog/pfsm_pkg.sv
// Purpose: shared constants and carriers for the pin function select mux
// Assumes: APB4 register access, 32-bit data, one aligned word per register
// Notes: selector fields are 2 bits, code 2'b10 picks the alternate function, 2'b01 the timer output on pd6 and pd4
`default_nettype none
package pfsm_pkg;
    // ********************************************************************
    // register byte offsets
    // ********************************************************************
    localparam logic [7:0] OFF_PC_HI_SEL = 8'h00;
    localparam logic [7:0] OFF_PD_HI_SEL = 8'h04;
    localparam logic [7:0] OFF_IN_SRC0 = 8'h08;
    localparam logic [7:0] OFF_IN_SRC1 = 8'h0c;
    localparam logic [7:0] OFF_WAKE_EN = 8'h10;
    localparam logic [7:0] OFF_WAKE_STAT = 8'h14;
    localparam logic [7:0] OFF_PORT_DATA = 8'h18;
    localparam logic [7:0] OFF_PORT_CTRL = 8'h1c;
    localparam logic [7:0] OFF_PIN_LEVEL = 8'h20;
    // ********************************************************************
    // field positions and codes
    // ********************************************************************
    localparam int PC6_FIELD_LSB = 4;
    localparam int PC5_FIELD_LSB = 2;
    localparam int PC4_FIELD_LSB = 0;
    localparam int PD7_FIELD_LSB = 6;
    localparam int PD6_FIELD_LSB = 4;
    localparam int PD5_FIELD_LSB = 2;
    localparam int PD4_FIELD_LSB = 0;
    localparam int RX1_PICK_BIT = 7;
    localparam int INTERRUPT_INPUT_TWO_PICK_BIT = 6;
    localparam int INTERRUPT_INPUT_ONE_PICK_BIT = 5;
    localparam int INTERRUPT_INPUT_ZERO_PICK_BIT = 4;
    localparam int SDI_PICK_BIT = 3;
    localparam int SCK_PICK_BIT = 2;
    localparam int SCS_PICK_BIT = 1;
    localparam int RX0_PICK_BIT = 0;
    localparam int T1CK_PICK_BIT = 0;
    localparam logic [1:0] FN_GPIO0 = 2'b00;
    localparam logic [1:0] FN_ALT1 = 2'b01;
    localparam logic [1:0] FN_ALT2 = 2'b10;
    localparam logic [1:0] FN_RSVD = 2'b11;
    localparam logic [5:0] PC_HI_SEL_MASK = 6'h3f;
    // ********************************************************************
    // reset values
    // ********************************************************************
    localparam logic [7:0] RST_SEL = 8'h00;
    localparam logic [31:0] RST_PORT = 32'hffffffff;
    localparam logic [7:0] RST_PIN_PREV = 8'hff;
    localparam logic INACTIVE_LEVEL = 1'b1;
    // ********************************************************************
    // carriers
    // ********************************************************************
    typedef struct packed {
        logic scs_o; logic scs_oe; logic sck_o; logic sck_oe;
        logic sda_o; logic sda_oe; logic u1_line_o; logic u1_line_oe;
        logic u1_tx; logic t1_out;
    } pfsm_periph_out_s;
    typedef struct packed {
        logic serial_chip_select; logic sck; logic sdi; logic interrupt_input_zero; logic interrupt_input_one;
        logic interrupt_input_two; logic rx0; logic rx1; logic t1_clk;
    } pfsm_periph_in_s;
endpackage : pfsm_pkg
`default_nettype wire

// file: verilog/pfsm_top.sv
// Purpose: pin function select mux for port C/D high pins and input sources
// Assumes: pin inputs synchronous to CORE_CLK, APB4 master on the bus side
// Notes: every output is registered, so routing changes show one cycle late
// Overview of operation
// - port C select bits 7..6 read zero
// - pc6 field: 10 connects serial chip select
// - pc5 field: 10 connects serial clock
// - pc4 field: 10 connects serial data
// - pd7 field: 10 gives second uart line
// - pd6 field: 01 timer out, 10 tx
// - pd5 field: 10 gives second uart line
// - pd4 field: 01 timer out, 10 tx
// - bit 7 picks second uart receive pin
// - bit 6 picks interrupt two pin
// - bit 5 picks interrupt one pin
// - bit 4 picks interrupt zero pin
// - bit 3 picks serial data pin
// - bit 2 picks serial clock pin
// - bit 1 picks chip select pin
// - bit 0 set takes pc1 for uart0
// - timer clock pick; upper bits read zero
// - reset sets port data and direction high
// - port A falling edge wakes sleep
`default_nettype none
module pfsm_top (
    input wire logic CORE_CLK, // system clock
    input wire logic RST, // async reset, high
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb enable
    input wire logic PWRITE, // apb direction
    input wire logic [7:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    input wire logic [3:0] PSTRB, // apb byte strobes
    output logic [31:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR, // unmapped address
    input wire logic [7:0] PA_IN, // port A pin levels
    input wire logic [7:0] PB_IN, // port B pin levels
    input wire logic [7:0] PC_IN, // port C pin levels
    input wire logic [7:0] PD_IN, // port D pin levels
    output logic [7:0] PA_OUT, // port A drive value
    output logic [7:0] PA_OE, // port A drive enable
    output logic [7:0] PB_OUT, // port B drive value
    output logic [7:0] PB_OE, // port B drive enable
    output logic [7:0] PC_OUT, // port C drive value
    output logic [7:0] PC_OE, // port C drive enable
    output logic [7:0] PD_OUT, // port D drive value
    output logic [7:0] PD_OE, // port D drive enable
    input wire logic [3:0] ALT_SEL_OK, // pa3 sdi, pb6 sck, pb5 scs, pc1 rx0
    input wire logic LOW_POWER, // sleep or idle active
    input wire pfsm_pkg::pfsm_periph_out_s PERIPH_OUT, // peripheral drives
    output pfsm_pkg::pfsm_periph_in_s PERIPH_IN, // routed inputs
    output logic WAKE_REQ // wake-up pulse
);
    import pfsm_pkg::*;

    // ********************************************************************
    // apb slave
    // ********************************************************************
    logic [5:0] pc_sel_q;
    logic [7:0] pd_sel_q;
    logic [7:0] src0_q;
    logic src1_q;
    logic [7:0] wake_en_q;
    logic [7:0] wake_st_q;
    logic [31:0] port_data_q;
    logic [31:0] port_ctrl_q;
    logic [7:0] pa_prev_q;
    logic acc;
    logic wr;
    logic hit;
    logic [31:0] rd_d;
    logic [7:0] fall;

    // one wait state: ready rises on the second access cycle
    assign acc = PSEL && PENABLE && PREADY;
    assign wr = acc && PWRITE && !PSLVERR;

    // address decode, narrow registers read zero above their width
    always_comb begin
        hit = 1'b1;
        rd_d = 32'h0;
        case (PADDR)
            OFF_PC_HI_SEL: rd_d = {26'h0, pc_sel_q};
            OFF_PD_HI_SEL: rd_d = {24'h0, pd_sel_q};
            OFF_IN_SRC0: rd_d = {24'h0, src0_q};
            OFF_IN_SRC1: rd_d = {31'h0, src1_q};
            OFF_WAKE_EN: rd_d = {24'h0, wake_en_q};
            OFF_WAKE_STAT: rd_d = {24'h0, wake_st_q};
            OFF_PORT_DATA: rd_d = port_data_q;
            OFF_PORT_CTRL: rd_d = port_ctrl_q;
            OFF_PIN_LEVEL: rd_d = {PD_IN, PC_IN, PB_IN, PA_IN};
            default: hit = 1'b0;
        endcase
    end

    // ready, read data and error all registered
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0;
            PSLVERR <= 1'b0;
        end else if (PSEL && PENABLE && !PREADY) begin
            PREADY <= 1'b1;
            PRDATA <= PWRITE ? 32'h0 : rd_d;
            PSLVERR <= !hit;
        end else begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end
    end

    // selector registers, low byte lane only
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            pc_sel_q <= RST_SEL[5:0];
            pd_sel_q <= RST_SEL;
            src0_q <= RST_SEL;
            src1_q <= RST_SEL[0];
            wake_en_q <= RST_SEL;
        end else if (wr && PSTRB[0]) begin
            case (PADDR)
                OFF_PC_HI_SEL: pc_sel_q <= PWDATA[5:0] & PC_HI_SEL_MASK;
                OFF_PD_HI_SEL: pd_sel_q <= PWDATA[7:0];
                OFF_IN_SRC0: src0_q <= PWDATA[7:0];
                OFF_IN_SRC1: src1_q <= PWDATA[T1CK_PICK_BIT];
                OFF_WAKE_EN: wake_en_q <= PWDATA[7:0];
                default: ;
            endcase
        end
    end

    // port data and direction, byte lanes honoured
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            port_data_q <= RST_PORT;
            port_ctrl_q <= RST_PORT;
        end else if (wr) begin
            for (int i = 0; i < 4; i++) begin
                if (PSTRB[i] && PADDR == OFF_PORT_DATA) begin
                    port_data_q[i*8 +: 8] <= PWDATA[i*8 +: 8];
                end
                if (PSTRB[i] && PADDR == OFF_PORT_CTRL) begin
                    port_ctrl_q[i*8 +: 8] <= PWDATA[i*8 +: 8];
                end
            end
        end
    end

    // ********************************************************************
    // port A wake-up
    // ********************************************************************
    assign fall = pa_prev_q & ~PA_IN & wake_en_q;

    // sticky edge record; a new edge beats a write-one-to-clear
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            pa_prev_q <= RST_PIN_PREV;
            wake_st_q <= RST_SEL;
            WAKE_REQ <= 1'b0;
        end else begin
            pa_prev_q <= PA_IN;
            WAKE_REQ <= LOW_POWER && (|fall);
            if (wr && PSTRB[0] && PADDR == OFF_WAKE_STAT) begin
                wake_st_q <= (wake_st_q & ~PWDATA[7:0]) | (LOW_POWER ? fall : 8'h0);
            end else if (LOW_POWER) begin
                wake_st_q <= wake_st_q | fall;
            end
        end
    end

    // ********************************************************************
    // output routing
    // ********************************************************************
    logic [7:0] pc_out_d;
    logic [7:0] pc_oe_d;
    logic [7:0] pd_out_d;
    logic [7:0] pd_oe_d;
    logic [1:0] f_pc6, f_pc5, f_pc4, f_pd7, f_pd6, f_pd5, f_pd4;

    assign f_pc6 = pc_sel_q[PC6_FIELD_LSB +: 2];
    assign f_pc5 = pc_sel_q[PC5_FIELD_LSB +: 2];
    assign f_pc4 = pc_sel_q[PC4_FIELD_LSB +: 2];
    assign f_pd7 = pd_sel_q[PD7_FIELD_LSB +: 2];
    assign f_pd6 = pd_sel_q[PD6_FIELD_LSB +: 2];
    assign f_pd5 = pd_sel_q[PD5_FIELD_LSB +: 2];
    assign f_pd4 = pd_sel_q[PD4_FIELD_LSB +: 2];

    // reserved codes release the pin rather than guess a function
    always_comb begin
        pc_out_d = port_data_q[23:16];
        pc_oe_d = ~port_ctrl_q[23:16];
        pd_out_d = port_data_q[31:24];
        pd_oe_d = ~port_ctrl_q[31:24];
        if (f_pc6 == FN_ALT2) begin
            pc_out_d[6] = PERIPH_OUT.scs_o;
            pc_oe_d[6] = PERIPH_OUT.scs_oe;
        end else if (f_pc6 == FN_RSVD) begin
            pc_oe_d[6] = 1'b0;
        end
        if (f_pc5 == FN_ALT2) begin
            pc_out_d[5] = PERIPH_OUT.sck_o;
            pc_oe_d[5] = PERIPH_OUT.sck_oe;
        end else if (f_pc5 == FN_RSVD) begin
            pc_oe_d[5] = 1'b0;
        end
        if (f_pc4 == FN_ALT2) begin
            pc_out_d[4] = PERIPH_OUT.sda_o;
            pc_oe_d[4] = PERIPH_OUT.sda_oe;
        end else if (f_pc4 == FN_RSVD) begin
            pc_oe_d[4] = 1'b0;
        end
        if (f_pd7 == FN_ALT2) begin
            pd_out_d[7] = PERIPH_OUT.u1_line_o;
            pd_oe_d[7] = PERIPH_OUT.u1_line_oe;
        end else if (f_pd7 == FN_RSVD) begin
            pd_oe_d[7] = 1'b0;
        end
        if (f_pd5 == FN_ALT2) begin
            pd_out_d[5] = PERIPH_OUT.u1_line_o;
            pd_oe_d[5] = PERIPH_OUT.u1_line_oe;
        end else if (f_pd5 == FN_RSVD) begin
            pd_oe_d[5] = 1'b0;
        end
        case (f_pd6)
            FN_ALT1: begin
                pd_out_d[6] = PERIPH_OUT.t1_out;
                pd_oe_d[6] = 1'b1;
            end
            FN_ALT2: begin
                pd_out_d[6] = PERIPH_OUT.u1_tx;
                pd_oe_d[6] = 1'b1;
            end
            FN_RSVD: pd_oe_d[6] = 1'b0;
            default: ;
        endcase
        case (f_pd4)
            FN_ALT1: begin
                pd_out_d[4] = PERIPH_OUT.t1_out;
                pd_oe_d[4] = 1'b1;
            end
            FN_ALT2: begin
                pd_out_d[4] = PERIPH_OUT.u1_tx;
                pd_oe_d[4] = 1'b1;
            end
            FN_RSVD: pd_oe_d[4] = 1'b0;
            default: ;
        endcase
    end

    // pins registered; ports A and B stay plain i/o here
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            PA_OUT <= RST_PORT[7:0];
            PA_OE <= 8'h00;
            PB_OUT <= RST_PORT[15:8];
            PB_OE <= 8'h00;
            PC_OUT <= RST_PORT[23:16];
            PC_OE <= 8'h00;
            PD_OUT <= RST_PORT[31:24];
            PD_OE <= 8'h00;
        end else begin
            PA_OUT <= port_data_q[7:0];
            PA_OE <= ~port_ctrl_q[7:0];
            PB_OUT <= port_data_q[15:8];
            PB_OE <= ~port_ctrl_q[15:8];
            PC_OUT <= pc_out_d;
            PC_OE <= pc_oe_d;
            PD_OUT <= pd_out_d;
            PD_OE <= pd_oe_d;
        end
    end

    // ********************************************************************
    // input source selection
    // ********************************************************************
    pfsm_periph_in_s in_d;
    logic pd5_gpio_in;
    logic pd7_gpio_in;

    // shared inputs need the i/o function and the direction set to input
    assign pd5_gpio_in = !f_pd5[1] && port_ctrl_q[29];
    assign pd7_gpio_in = !f_pd7[1] && port_ctrl_q[31];

    // a source not assigned to its function holds the input idle
    always_comb begin
        in_d = '{default: INACTIVE_LEVEL};
        if (src0_q[RX1_PICK_BIT]) begin
            if (f_pd7 == FN_ALT2) in_d.rx1 = PD_IN[7];
        end else begin
            if (f_pd5 == FN_ALT2) in_d.rx1 = PD_IN[5];
        end
        if (src0_q[INTERRUPT_INPUT_TWO_PICK_BIT]) begin
            if (pd5_gpio_in) in_d.interrupt_input_two = PD_IN[5];
        end else begin
            if (pd7_gpio_in) in_d.interrupt_input_two = PD_IN[7];
        end
        if (src0_q[INTERRUPT_INPUT_ONE_PICK_BIT]) begin
            if (port_ctrl_q[2]) in_d.interrupt_input_one = PA_IN[2];
        end else begin
            if (port_ctrl_q[9]) in_d.interrupt_input_one = PB_IN[1];
        end
        if (src0_q[INTERRUPT_INPUT_ZERO_PICK_BIT]) begin
            if (port_ctrl_q[1]) in_d.interrupt_input_zero = PA_IN[1];
        end else begin
            if (port_ctrl_q[8]) in_d.interrupt_input_zero = PB_IN[0];
        end
        if (src0_q[SDI_PICK_BIT]) begin
            if (ALT_SEL_OK[0]) in_d.sdi = PA_IN[3];
        end else begin
            if (f_pc4 == FN_ALT2) in_d.sdi = PC_IN[4];
        end
        if (src0_q[SCK_PICK_BIT]) begin
            if (ALT_SEL_OK[1]) in_d.sck = PB_IN[6];
        end else begin
            if (f_pc5 == FN_ALT2) in_d.sck = PC_IN[5];
        end
        if (src0_q[SCS_PICK_BIT]) begin
            if (ALT_SEL_OK[2]) in_d.serial_chip_select = PB_IN[5];
        end else begin
            if (f_pc6 == FN_ALT2) in_d.serial_chip_select = PC_IN[6];
        end
        // the cleared pick is reserved, so it routes nothing
        if (src0_q[RX0_PICK_BIT] && ALT_SEL_OK[3]) begin
            in_d.rx0 = PC_IN[1];
        end
        if (src1_q) begin
            if (pd7_gpio_in) in_d.t1_clk = PD_IN[7];
        end else begin
            if (pd5_gpio_in) in_d.t1_clk = PD_IN[5];
        end
    end

    // registered so peripherals never see a decode glitch
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            PERIPH_IN <= '{default: INACTIVE_LEVEL};
        end else begin
            PERIPH_IN <= in_d;
        end
    end

    // ********************************************************************
    // assertions
    // ********************************************************************
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    pc_top_zero_a: assert property (
        acc && !PWRITE && PADDR == OFF_PC_HI_SEL |-> PRDATA[31:6] == 26'h0)
        else $error("port C select top bits not zero");
    scs_route_a: assert property (
        f_pc6 == FN_ALT2 |=> PC_OE[6] == $past(PERIPH_OUT.scs_oe))
        else $error("chip select not routed to pc6");
    sck_route_a: assert property (
        f_pc5 == FN_ALT2 |=> PC_OUT[5] == $past(PERIPH_OUT.sck_o))
        else $error("serial clock not routed to pc5");
    sda_route_a: assert property (
        f_pc4 == FN_ALT2 |=> PC_OUT[4] == $past(PERIPH_OUT.sda_o))
        else $error("serial data not routed to pc4");
    pd6_timer_a: assert property (
        f_pd6 == FN_ALT1 |=> PD_OE[6] && PD_OUT[6] == $past(PERIPH_OUT.t1_out))
        else $error("timer output not on pd6");
    pd4_tx_a: assert property (
        f_pd4 == FN_ALT2 |=> PD_OE[4] && PD_OUT[4] == $past(PERIPH_OUT.u1_tx))
        else $error("uart transmit not on pd4");
    rx1_pick_a: assert property (
        src0_q[RX1_PICK_BIT] && f_pd7 == FN_ALT2 |=> PERIPH_IN.rx1 == $past(PD_IN[7]))
        else $error("second uart receive not from pd7");
    scs_idle_a: assert property (
        !src0_q[SCS_PICK_BIT] && f_pc6 != FN_ALT2 |=> PERIPH_IN.serial_chip_select == INACTIVE_LEVEL)
        else $error("chip select input not held idle");
    wake_fall_a: assert property (
        LOW_POWER && $fell(PA_IN[0]) && wake_en_q[0] |-> ##1 WAKE_REQ)
        else $error("no wake on port A falling edge");
    wake_quiet_a: assert property (
        !LOW_POWER |=> !WAKE_REQ)
        else $error("wake outside low power");

    wake_seen_c: cover property (LOW_POWER ##1 WAKE_REQ);
    rx1_pd7_c: cover property (src0_q[RX1_PICK_BIT] && f_pd7 == FN_ALT2);
    bus_err_c: cover property (PREADY && PSLVERR);
endmodule : pfsm_top
`default_nettype wire
